// ### hdl/hbc_bus_seq.sv
// hbc_bus_seq: bus cycle state machine for the external local bus
`timescale 1ns/10ps
`default_nettype none
// Contract
// - sample and drive bus on rising clock
// - capture frequency select at reset release
// - flush sampled at reset release and clocks
// - scan: capture on TCK rise, drive fall
// - active low asserted low, high high
// - idle leaves bus undriven until request
// - idle after final ready in data state
// - reset or backoff forces idle immediately
// - address strobe one clock, then data
// - data waits for next-address or final ready
// - final ready wins; next-address goes waiting
// - waiting: final ready to idle or address
// - pipeline address strobes, then pipeline data
// - reversal on final ready inserts transition
// - next-address ignored in pipeline address
// - pipeline data issues no further cycles
// - pipeline data final ready: transition, data, waiting
// - transition lasts one clock, then data, or waiting on next-address
// - ready sampled from edge after strobe negates
// - burst ends on fourth ready, single first
// - idle clock between non-pipelined cycles; none when waiting-state final ready meets a request
module hbc_bus_seq
	import hbc_pkg::*;
(
	// clock, reset and enable
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// bus inputs from the chipset
	input wire hbc_busin_t busIn,
	input wire logic [FREQ_W-1:0] busFreqSel,
	input wire logic cacheFlushReqN,
	// internal cycle request
	input wire logic reqValid,
	input wire hbc_cycle_t reqCycle,
	// boundary scan pins
	input wire logic scanMode,
	input wire logic tck,
	input wire logic tdi,
	// bus outputs
	output logic addrStrobeN,
	output logic busDriveEn,
	output logic dataDirWrite,
	// internal status
	output logic reqTaken,
	output logic cycleDone,
	output hbc_state_t busState,
	output logic [FREQ_W-1:0] busFreqLatched,
	output logic flushPending,
	output logic tdo
);

	// asserted-sense views of the active-low bus inputs
	logic burst_ready_n;
	logic naReq;
	logic backoff;
	// state and its next value
	hbc_state_t state;
	hbc_state_t next_state;
	// current and pipelined cycle attributes
	hbc_cycle_t curCycle;
	hbc_cycle_t pendCycle;
	// ready beats counted in the current cycle
	logic [BEAT_W-1:0] beatCnt;
	// next-address seen while two cycles are outstanding
	logic naSeen;
	// decoded events
	logic sampleReady;
	logic lastBeat;
	logic reversal;
	logic startCycle;
	// reset release tracking
	logic rstSeen;
	// synchronised asynchronous pins
	logic flushSyncN;
	logic tckSync;
	logic tdiSync;
	logic scanSync;
	logic tckPrev;
	logic [BSCAN_LEN-1:0] scanChain;

	// pins inside the chip's clock domain use plain sense inversion
	assign burst_ready_n = !busIn.burstReadyN;
	assign naReq = !busIn.nextAddrReqN;
	assign backoff = !busIn.busBackoffN;

	// flush and scan pins arrive from outside the clock
	hbc_sync #(
		.WIDTH(4),
		.INIT(4'H8)
	) u_sync (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.asyncIn({cacheFlushReqN, tck, tdi, scanMode}),
		.syncOut({flushSyncN, tckSync, tdiSync, scanSync})
	);

	// ready is looked at only after the strobe clock has ended
	always_comb begin
		sampleReady = (state == ST_DATA) || (state == ST_NAWAIT) ||
			(state == ST_PIPEADDR) || (state == ST_PIPEDATA);
	end

	// final ready: fourth beat of a burst, first of a single
	always_comb begin
		lastBeat = sampleReady && burst_ready_n &&
			(beatCnt == (curCycle.burst ? BEAT_LAST : BEAT_FIRST));
	end

	// direction change between current and pipelined cycle
	assign reversal = (curCycle.write != pendCycle.write);

	// next state
	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				// stays idle until the core asks for a cycle
				if (reqValid) begin
					next_state = ST_ADDR;
				end
			end
			ST_ADDR: begin
				// strobe lasts one clock
				next_state = ST_DATA;
			end
			ST_DATA: begin
				// final ready wins over a coincident next-address
				if (lastBeat) begin
					next_state = ST_IDLE;
				end else if (naReq) begin
					next_state = ST_NAWAIT;
				end
			end
			ST_NAWAIT: begin
				// final ready before a new cycle is driven
				if (lastBeat) begin
					next_state = reqValid ? ST_ADDR : ST_IDLE;
				end else if (reqValid) begin
					next_state = ST_PIPEADDR;
				end
			end
			ST_PIPEADDR: begin
				// next-address is not looked at here
				if (lastBeat) begin
					next_state = reversal ? ST_TRANS : ST_DATA;
				end else begin
					next_state = ST_PIPEDATA;
				end
			end
			ST_PIPEDATA: begin
				// two cycles outstanding, nothing new issued
				if (lastBeat) begin
					if (reversal) begin
						next_state = ST_TRANS;
					end else begin
						next_state = (naSeen || naReq) ? ST_NAWAIT : ST_DATA;
					end
				end
			end
			ST_TRANS: begin
				// one turnaround clock
				next_state = naReq ? ST_NAWAIT : ST_DATA;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		// backoff aborts from any state on the edge it is seen
		if (backoff) begin
			next_state = ST_IDLE;
		end
	end

	// a new strobe is launched
	assign startCycle = (next_state == ST_ADDR) || (next_state == ST_PIPEADDR);

	// state register, rising edge only
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			state <= ST_IDLE;
		end else if (clk_en) begin
			state <= next_state;
		end
	end

	// bus pin outputs registered from the next state
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			addrStrobeN <= 1'H1;
			busDriveEn <= 1'H0;
			busState <= ST_IDLE;
		end else if (clk_en) begin
			addrStrobeN <= !startCycle;
			busDriveEn <= (next_state != ST_IDLE) && (next_state != ST_TRANS);
			busState <= next_state;
		end
	end

	// current cycle attributes and direction pin
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			curCycle <= '0;
			pendCycle <= '0;
			dataDirWrite <= 1'H0;
		end else if (clk_en) begin
			if (next_state == ST_ADDR) begin
				curCycle <= reqCycle;
				dataDirWrite <= reqCycle.write;
			end else if (next_state == ST_PIPEADDR) begin
				pendCycle <= reqCycle;
			end else if (lastBeat && (state == ST_PIPEADDR || state == ST_PIPEDATA)) begin
				// pipelined cycle becomes current
				curCycle <= pendCycle;
				dataDirWrite <= pendCycle.write;
			end
		end
	end

	// ready beat counter
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			beatCnt <= BEAT_FIRST;
		end else if (clk_en) begin
			if (backoff || lastBeat || next_state == ST_ADDR) begin
				beatCnt <= BEAT_FIRST;
			end else if (sampleReady && burst_ready_n) begin
				beatCnt <= beatCnt + 1'H1;
			end
		end
	end

	// next-address remembered during pipeline data
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			naSeen <= 1'H0;
		end else if (clk_en) begin
			if (state != ST_PIPEDATA || lastBeat || backoff) begin
				naSeen <= 1'H0;
			end else if (naReq) begin
				naSeen <= 1'H1;
			end
		end
	end

	// one-clock status pulses
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			reqTaken <= 1'H0;
			cycleDone <= 1'H0;
		end else if (clk_en) begin
			reqTaken <= startCycle;
			cycleDone <= lastBeat && !backoff;
		end
	end

	// frequency select captured on the first enabled clock after release
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rstSeen <= 1'H0;
			busFreqLatched <= FREQ_RESET;
		end else if (clk_en && !rstSeen) begin
			rstSeen <= 1'H1;
			busFreqLatched <= busFreqSel;
		end
	end

	// flush request: captured at release, then on every clock
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			flushPending <= 1'H0;
		end else if (clk_en) begin
			if (!flushSyncN) begin
				flushPending <= 1'H1;
			end else if (next_state == ST_ADDR) begin
				flushPending <= 1'H0;
			end
		end
	end

	// scan chain: capture on tck rise, shift out on tck fall
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			tckPrev <= 1'H0;
			scanChain <= BSCAN_RESET;
			tdo <= 1'H0;
		end else if (clk_en) begin
			tckPrev <= tckSync;
			if (scanSync && tckSync && !tckPrev) begin
				scanChain <= {scanChain[BSCAN_LEN-2:0], tdiSync};
			end
			if (scanSync && !tckSync && tckPrev) begin
				tdo <= scanChain[BSCAN_LEN-1];
			end
		end
	end

	// checks, on enabled clocks only
	default clocking cb @(posedge core_clk iff clk_en);
	endclocking
	default disable iff (!rst_n);

	sequence seq_final_data;
		state == ST_DATA && lastBeat && !backoff;
	endsequence

	sequence seq_strobe_clock;
		state == ST_ADDR && !backoff;
	endsequence

	a_strobe_in_addr: assert property (
		(state == ST_ADDR || state == ST_PIPEADDR) |-> !addrStrobeN
	) else $error("strobe not asserted in an address state");

	a_addr_to_data: assert property (
		seq_strobe_clock |=> state == ST_DATA ##0 addrStrobeN
	) else $error("address state did not end in data after one clock");

	a_backoff_idle: assert property (
		backoff |=> state == ST_IDLE && addrStrobeN
	) else $error("backoff did not force idle");

	a_final_idle: assert property (
		seq_final_data |=> state == ST_IDLE
	) else $error("final ready in data did not go idle");

	a_idle_gap: assert property (
		seq_final_data |=> addrStrobeN && !busDriveEn
	) else $error("strobe issued without an idle clock");

	a_na_wait: assert property (
		(state == ST_DATA && !lastBeat && naReq && !backoff) |=> state == ST_NAWAIT
	) else $error("next-address in data did not reach waiting state");

	a_pipeaddr_no_na: assert property (
		state == ST_PIPEADDR |=> state != ST_NAWAIT
	) else $error("pipeline address went straight to waiting state");

	a_pipe_no_issue: assert property (
		state == ST_PIPEDATA |-> addrStrobeN
	) else $error("strobe issued with two cycles outstanding");

	a_trans_single: assert property (
		(state == ST_TRANS && !backoff && !naReq) |=> state == ST_DATA
	) else $error("transition state lasted more than one clock");

	a_reversal_trans: assert property (
		(state == ST_PIPEADDR && lastBeat && reversal && !backoff) |=> state == ST_TRANS
	) else $error("direction reversal without transition clock");

	a_freq_capture: assert property (
		!rstSeen |=> busFreqLatched == $past(busFreqSel)
	) else $error("frequency select not captured at reset release");

endmodule
`default_nettype wire

// ### hdl/hbc_pkg.sv
// hbc_pkg: shared states, carriers and constants for the host bus cycle sequencer
package hbc_pkg;

	// bus cycle states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_DATA,
		ST_NAWAIT,
		ST_PIPEADDR,
		ST_PIPEDATA,
		ST_TRANS
	} hbc_state_t;

	// bus inputs returned by the chipset, all active low
	typedef struct packed {
		logic burstReadyN;
		logic nextAddrReqN;
		logic busBackoffN;
	} hbc_busin_t;

	// attributes of one bus cycle
	typedef struct packed {
		logic write;
		logic burst;
	} hbc_cycle_t;

	// beats in a burst and width of the beat counter
	localparam int BURST_BEATS = 4;
	localparam int BEAT_W = 2;
	localparam logic [BEAT_W-1:0] BEAT_LAST = 2'H3;
	localparam logic [BEAT_W-1:0] BEAT_FIRST = 2'H0;
	// width of the bus frequency selection
	localparam int FREQ_W = 3;
	localparam logic [FREQ_W-1:0] FREQ_RESET = 3'H0;
	// synchroniser stages for inputs from outside the clock
	localparam int SYNC_STAGES = 3;
	// bits of the boundary capture chain
	localparam int BSCAN_LEN = 8;
	localparam logic [BSCAN_LEN-1:0] BSCAN_RESET = 8'H00;

endpackage

// ### hdl/hbc_sync.sv
// hbc_sync: three-stage synchroniser that passes a change once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module hbc_sync
	import hbc_pkg::*;
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// clock, reset and enable
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// asynchronous in, filtered out
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	// stage chain; stage 0 is read only by stage 1
	logic [WIDTH-1:0] stage [SYNC_STAGES];

	// shift the chain
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < SYNC_STAGES; i++) begin
				stage[i] <= INIT;
			end
		end else if (clk_en) begin
			stage[0] <= asyncIn;
			for (int i = 1; i < SYNC_STAGES; i++) begin
				stage[i] <= stage[i-1];
			end
		end
	end

	// accept a bit only when the last two stages agree
	genvar b;
	generate
		for (b = 0; b < WIDTH; b++) begin : g_bit
			always_ff @(posedge core_clk) begin
				if (!rst_n) begin
					syncOut[b] <= INIT[b];
				end else if (clk_en && (stage[1][b] == stage[2][b])) begin
					syncOut[b] <= stage[2][b];
				end
			end
		end
	endgenerate
endmodule
`default_nettype wire

// ### test/hbc_chipset_model.sv
// hbc_chipset_model: chipset stand-in answering strobes with ready, next-address and backoff
`timescale 1ns/10ps
`default_nettype none
module hbc_chipset_model
	import hbc_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// controls from the bench
	input wire logic burstMode,
	input wire logic slowMode,
	input wire logic naOn,
	input wire logic boffReq,
	// bus
	input wire logic addrStrobeN,
	output var hbc_busin_t busIn
);
	logic [1:0] pend; // cycles strobed, not yet finished
	logic [1:0] beat; // ready beats given in the current cycle
	logic tick; // wait-state toggle in slow mode
	logic done; // final ready on the bus now
	logic [1:0] live; // cycles outstanding after this edge
	assign done = !busIn.burstReadyN && (beat == (burstMode ? 2'H3 : 2'H0));
	assign live = pend + {1'b0, !addrStrobeN} - {1'b0, done};
	// answers change just after the edge; negated lines rest high
	always_ff @(posedge core_clk) begin
		if (!rst_n || !busIn.busBackoffN) begin
			pend <= 2'H0;
			beat <= 2'H0;
			tick <= 1'b0;
			busIn.burstReadyN <= 1'b1;
			busIn.nextAddrReqN <= 1'b1;
		end else begin
			pend <= live;
			beat <= done ? 2'H0 : beat + {1'b0, !busIn.burstReadyN};
			tick <= (live != 2'H0) && !tick;
			// first ready only after the edge that ends the strobe
			busIn.burstReadyN <= !((live != 2'H0) && (!slowMode || tick));
			busIn.nextAddrReqN <= !(naOn && !addrStrobeN);
		end
		busIn.busBackoffN <= !(rst_n && boffReq);
	end
endmodule
`default_nettype wire

// ### test/tb_top.sv
// tb_top: self-checking bench for the bus cycle sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import hbc_pkg::*;
;
	// one plain cycle: write, burst, slow, expected clocks from taken to done
	typedef struct {logic w; logic b; logic s; int len;} hbc_row_t;
	hbc_row_t rows [5] = '{'{1'b0, 1'b0, 1'b0, 2}, '{1'b1, 1'b0, 1'b0, 2},
		'{1'b0, 1'b1, 1'b0, 5}, '{1'b1, 1'b1, 1'b1, 9}, '{1'b0, 1'b0, 1'b1, 3}};
	logic core_clk, rst_n, cacheFlushReqN, reqValid, scanMode, tck, tdi;
	logic burstMode, slowMode, naOn, boffReq;
	logic clkEn; // design clock enable
	logic [FREQ_W-1:0] busFreqSel, busFreqLatched;
	hbc_cycle_t reqCycle;
	hbc_busin_t busIn;
	hbc_state_t busState;
	logic addrStrobeN, busDriveEn, dataDirWrite, reqTaken, cycleDone, flushPending, tdo;
	int badCount = 0;
	int nTests = 0;
	int doneCnt = 0; // finished cycles
	int transCnt = 0; // clocks spent in turnaround
	int len;
	hbc_bus_seq dut (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clkEn), .busIn(busIn),
		.busFreqSel(busFreqSel), .cacheFlushReqN(cacheFlushReqN), .reqValid(reqValid),
		.reqCycle(reqCycle), .scanMode(scanMode), .tck(tck), .tdi(tdi),
		.addrStrobeN(addrStrobeN), .busDriveEn(busDriveEn), .dataDirWrite(dataDirWrite),
		.reqTaken(reqTaken), .cycleDone(cycleDone), .busState(busState),
		.busFreqLatched(busFreqLatched), .flushPending(flushPending), .tdo(tdo));
	hbc_chipset_model chipset (.core_clk(core_clk), .rst_n(rst_n), .burstMode(burstMode),
		.slowMode(slowMode), .naOn(naOn), .boffReq(boffReq), .addrStrobeN(addrStrobeN),
		.busIn(busIn));
	// 200 MHz clock
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// counts finished cycles and turnaround clocks
	always @(posedge core_clk) begin
		if (cycleDone === 1'b1) doneCnt++;
		if (busState === ST_TRANS) transCnt++;
	end
	// compares and reports
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		nTests++;
		if (seen !== exp) begin
			badCount++;
			$display("Error %s expected %0h seen %0h", what, exp, seen);
		end
	endtask
	// verdict and end of run
	task automatic finishTest();
		$display("checks %0d mismatches %0d", nTests, badCount);
		if (badCount == 0 && nTests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// one non-pipelined cycle, entered at a falling edge with the bus idle
	task automatic run_cycle(input logic w, input logic b, output int n);
		int k;
		reqValid = 1'b1;
		reqCycle = '{write: w, burst: b};
		burstMode = b;
		k = 0;
		do begin @(negedge core_clk); k++; end while (reqTaken !== 1'b1 && k < 50);
		reqValid = 1'b0;
		check(k, 1, "take delay");
		check(addrStrobeN, 1'b0, "strobe");
		@(negedge core_clk);
		check(addrStrobeN, 1'b1, "strobe end");
		check(dataDirWrite, w, "direction");
		n = 1;
		while (cycleDone !== 1'b1 && n < 60) begin @(negedge core_clk); n++; end
	endtask
	// pipelined pair of slow bursts, read then read or write
	task automatic run_pipe(input logic rev);
		int k;
		naOn = 1'b1;
		slowMode = 1'b1;
		burstMode = 1'b1;
		doneCnt = 0;
		transCnt = 0;
		reqValid = 1'b1;
		reqCycle = '{write: 1'b0, burst: 1'b1};
		k = 0;
		do begin @(negedge core_clk); k++; end while (reqTaken !== 1'b1 && k < 50);
		reqCycle = '{write: rev, burst: 1'b1};
		do begin @(negedge core_clk); k++; end while (reqTaken !== 1'b1 && k < 50);
		reqValid = 1'b0;
		naOn = 1'b0;
		check(doneCnt, 0, "pipelined start");
		while (doneCnt < 2 && k < 100) begin @(negedge core_clk); k++; end
		check(doneCnt, 2, "pipelined done");
		check(transCnt, rev, "turnaround clocks");
		check(dataDirWrite, rev, "pipelined direction");
	endtask
	// watchdog
	initial begin
		#25000;
		badCount++;
		finishTest();
	end
	// main sequence
	initial begin
		{rst_n, cacheFlushReqN, reqValid, scanMode, tck, tdi} = 6'H02;
		{burstMode, slowMode, naOn, boffReq} = 4'H0;
		clkEn = 1'b1;
		reqCycle = '{write: 1'b0, burst: 1'b0};
		busFreqSel = 3'H5;
		repeat (5) @(negedge core_clk);
		check(addrStrobeN, 1'b1, "reset strobe");
		check(busDriveEn, 1'b0, "reset drive");
		check(busState, ST_IDLE, "reset state");
		rst_n = 1'b1;
		repeat (2) @(negedge core_clk);
		busFreqSel = 3'H2;
		repeat (4) @(negedge core_clk);
		check(busFreqLatched, 3'H5, "frequency select");
		foreach (rows[i]) begin
			slowMode = rows[i].s;
			run_cycle(rows[i].w, rows[i].b, len);
			check(len, rows[i].len, "cycle length");
		end
		@(negedge core_clk);
		run_pipe(1'b1);
		run_pipe(1'b0);
		// backoff in mid-burst
		run_cycle(1'b1, 1'b1, len);
		check(len, 9, "slow write burst");
		slowMode = 1'b1;
		reqValid = 1'b1;
		do @(negedge core_clk); while (reqTaken !== 1'b1);
		reqValid = 1'b0;
		repeat (3) @(negedge core_clk);
		boffReq = 1'b1;
		@(negedge core_clk);
		boffReq = 1'b0;
		repeat (2) @(negedge core_clk);
		check(busState, ST_IDLE, "backoff state");
		check(busDriveEn, 1'b0, "backoff drive");
		slowMode = 1'b0;
		run_cycle(1'b0, 1'b0, len);
		check(len, 2, "after backoff");
		// early next-address with nothing pending ends in idle
		naOn = 1'b1;
		run_cycle(1'b0, 1'b1, len);
		naOn = 1'b0;
		check(len, 5, "early address then idle");
		// enable low freezes the sequencer despite a request
		clkEn = 1'b0;
		reqValid = 1'b1;
		repeat (3) @(negedge core_clk);
		check(busState, ST_IDLE, "frozen state");
		check(reqTaken, 1'b0, "frozen request");
		clkEn = 1'b1;
		reqValid = 1'b0;
		@(negedge core_clk);
		check(busState, ST_IDLE, "after freeze");
		// flush request through the synchroniser
		cacheFlushReqN = 1'b0;
		repeat (4) @(negedge core_clk);
		cacheFlushReqN = 1'b1;
		repeat (4) @(negedge core_clk);
		check(flushPending, 1'b1, "flush");
		run_cycle(1'b1, 1'b0, len);
		check(flushPending, 1'b0, "flush cleared");
		// boundary chain filled with ones
		scanMode = 1'b1;
		tdi = 1'b1;
		repeat (9) begin
			repeat (6) @(negedge core_clk);
			tck = 1'b1;
			repeat (6) @(negedge core_clk);
			tck = 1'b0;
		end
		repeat (8) @(negedge core_clk);
		check(tdo, 1'b1, "scan out");
		finishTest();
	end
endmodule
`default_nettype wire
